// ---- verilog/ris_map.svh ----
// Register field positions, reset values and control bus codes for the interrupt source select.
`ifndef RIS_MAP_SVH
`define RIS_MAP_SVH

// Chip address sent while the enable line is low.
`define RIS_CHIP_ADDR 8'hE8
// Command address field DI7..DI2 of the source enable command.
`define RIS_CMD_CODE 6'h20
// Number of data bits in one command frame.
`define RIS_FRAME_BITS 5'h10

// Reset value of the source enable register.
`define RIS_ENABLES_RESET 8'h00

// Source enable bit positions, DI8 upward.
`define RIS_BIT_ERROR 3'h0
`define RIS_BIT_DETECT 3'h1
`define RIS_BIT_LOCK 3'h2
`define RIS_BIT_CS 3'h3
`define RIS_BIT_NONPCM 3'h4
`define RIS_BIT_PC 3'h5
`define RIS_BIT_SLIP 3'h6
`define RIS_BIT_EMPH 3'h7

// Channel status capture length per block.
`define RIS_CS_BITS 6'h30
`define RIS_CS_LAST 6'h2F

`endif

// ---- verilog/ris_pkg.sv ----
// Types shared by the interrupt source select design.
package ris_pkg;

	typedef enum logic {
		RIS_ST_ADDR,
		RIS_ST_DATA
	} ris_bus_state_t;

	typedef logic [7:0] ris_enables_t;

endpackage

// ---- verilog/ris_ctl_rx.sv ----
// Serial control bus receiver that decodes the source enable command.
`timescale 1ns/1ns
`include "ris_map.svh"

module ris_ctl_rx
	import ris_pkg::*;
(
	input wire logic clk_sys_i, // System clock.
	input wire logic reset_n_i, // Asynchronous reset, active low.
	input wire logic ctl_clk_i, // Control bus shift clock pin.
	input wire logic ctl_ce_i, // Control bus enable pin.
	input wire logic ctl_di_i, // Control bus data pin.
	input wire logic chip_address_upper_i, // Address strap, upper.
	input wire logic chip_address_lower_i, // Address strap, lower.
	output logic wr_valid_o, // One-cycle pulse on an accepted command.
	output ris_enables_t wr_data_o // Enable bits DI15..DI8.
);

	////////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for all pins, plus a third stage for edges.
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [1:0] prev;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			prev <= 2'h0;
		end else begin
			sync1 <= {chip_address_lower_i, chip_address_upper_i, ctl_di_i, ctl_ce_i, ctl_clk_i};
			sync2 <= sync1;
			prev <= sync2[1:0];
		end
	end

	logic clk_rise;
	logic ce_rise;
	logic ce_fall;
	assign clk_rise = sync2[0] & ~prev[0];
	assign ce_rise = sync2[1] & ~prev[1];
	assign ce_fall = ~sync2[1] & prev[1];

	////////////////////////////////////////////////////////////////////////////////
	// Frame shifting: chip address while enable is low, data while it is high.
	ris_bus_state_t state;
	ris_bus_state_t next_state;
	logic [7:0] chip;
	logic [7:0] next_chip;
	logic [15:0] shift;
	logic [15:0] next_shift;
	logic [4:0] count;
	logic [4:0] next_count;
	logic next_wr_valid;
	ris_enables_t next_wr_data;

	always_comb begin
		next_state = state;
		next_chip = chip;
		next_shift = shift;
		next_count = count;
		next_wr_valid = 1'b0;
		next_wr_data = wr_data_o;
		if (ce_rise) begin
			next_state = RIS_ST_DATA;
			next_count = 5'h00;
		end else if (ce_fall) begin
			next_state = RIS_ST_ADDR;
			next_chip = 8'h00;
			if (state == RIS_ST_DATA && count == `RIS_FRAME_BITS && chip == `RIS_CHIP_ADDR
				&& shift[7:2] == `RIS_CMD_CODE && shift[1] == sync2[3]
				&& shift[0] == sync2[4]) begin
				next_wr_valid = 1'b1;
				next_wr_data = shift[15:8];
			end
		end else if (clk_rise) begin
			if (state == RIS_ST_ADDR) begin
				next_chip = {sync2[2], chip[7:1]};
			end else if (count != `RIS_FRAME_BITS) begin
				next_shift = {sync2[2], shift[15:1]};
				next_count = count + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= RIS_ST_ADDR;
			chip <= 8'h00;
			shift <= 16'h0000;
			count <= 5'h00;
			wr_valid_o <= 1'b0;
			wr_data_o <= `RIS_ENABLES_RESET;
		end else begin
			state <= next_state;
			chip <= next_chip;
			shift <= next_shift;
			count <= next_count;
			wr_valid_o <= next_wr_valid;
			wr_data_o <= next_wr_data;
		end
	end

endmodule

// ---- verilog/ris_top.sv ----
// Receiver interrupt source select: enable register, update flags, slip detection.
`timescale 1ns/1ns
`include "ris_map.svh"


module ris_top
	import ris_pkg::*;
(
	input wire logic clk_sys_i, // System clock, 100 MHz.
	input wire logic reset_n_i, // Asynchronous reset, active low.
	input wire logic ctl_clk_i, // Control bus shift clock pin.
	input wire logic ctl_ce_i, // Control bus enable pin.
	input wire logic ctl_di_i, // Control bus data pin.
	input wire logic chip_address_upper_i, // Address strap, upper.
	input wire logic chip_address_lower_i, // Address strap, lower.
	input wire logic receive_error_pin_i, // Error pin state from the core.
	input wire logic input_detect_change_i, // Input detection change flag.
	input wire logic lock_freq_update_i, // New lock frequency result flag.
	input wire logic non_pcm_detect_i, // Non-PCM detection flag.
	input wire logic emphasis_detect_i, // Emphasis detection flag.
	input wire logic slave_mode_i, // High while operating as slave.
	input wire logic rx_word_i, // Pulse: received word written.
	input wire logic out_word_i, // Pulse: output word read.
	input wire logic cs_bit_valid_i, // Pulse: channel status bit present.
	input wire logic cs_bit_i, // Channel status bit value.
	input wire logic cs_block_start_i, // Marks the first bit of a block.
	input wire logic pc_valid_i, // Pulse: burst Pc value present.
	input wire logic [15:0] pc_value_i, // Burst preamble Pc value.
	output logic int_o, // Interrupt output, active high.
	output logic cs_update_o, // Channel status update flag.
	output logic pc_update_o, // Pc update flag.
	output logic slip_o // Slave slip flag.
);

	////////////////////////////////////////////////////////////////////////////////
	// Source enable register, written over the control bus.
	logic wr_valid;
	ris_enables_t wr_data;
	ris_enables_t enables;
	ris_enables_t next_enables;

	ris_ctl_rx u_ctl_rx (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.ctl_clk_i(ctl_clk_i),
		.ctl_ce_i(ctl_ce_i),
		.ctl_di_i(ctl_di_i),
		.chip_address_upper_i(chip_address_upper_i),
		.chip_address_lower_i(chip_address_lower_i),
		.wr_valid_o(wr_valid),
		.wr_data_o(wr_data)
	);

	always_comb begin
		next_enables = wr_valid ? wr_data : enables;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel status capture and block-to-block compare.
	logic [5:0] cs_cnt;
	logic [5:0] next_cs_cnt;
	logic [5:0] cs_idx;
	logic [47:0] cs_cur;
	logic [47:0] next_cs_cur;
	logic [47:0] cs_prev;
	logic [47:0] next_cs_prev;
	logic [47:0] cs_word;
	logic cs_prev_valid;
	logic next_cs_prev_valid;
	logic next_cs_update;
	logic cs_cmp_now;

	always_comb begin
		cs_idx = cs_block_start_i ? 6'h00 : cs_cnt;
		cs_word = cs_cur;
		cs_word[cs_idx] = cs_bit_i;
		next_cs_cnt = cs_cnt;
		next_cs_cur = cs_cur;
		next_cs_prev = cs_prev;
		next_cs_prev_valid = cs_prev_valid;
		next_cs_update = cs_update_o;
		cs_cmp_now = 1'b0;
		if (cs_bit_valid_i && cs_idx < `RIS_CS_BITS) begin
			next_cs_cur = cs_word;
			next_cs_cnt = cs_idx + 6'h01;
			if (cs_idx == `RIS_CS_LAST) begin
				cs_cmp_now = 1'b1;
				next_cs_update = cs_prev_valid && (cs_word == cs_prev);
				next_cs_prev = cs_word;
				next_cs_prev_valid = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Burst preamble Pc compare against the previous burst.
	logic [15:0] pc_prev;
	logic [15:0] next_pc_prev;
	logic pc_have;
	logic next_pc_have;
	logic next_pc_update;

	always_comb begin
		next_pc_prev = pc_prev;
		next_pc_have = pc_have;
		next_pc_update = pc_update_o;
		if (pc_valid_i) begin
			next_pc_update = pc_have && (pc_value_i == pc_prev);
			next_pc_prev = pc_value_i;
			next_pc_have = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slave slip: a read with no new word, or a new word with no read.
	logic fresh;
	logic next_fresh;
	logic slip_dup;
	logic slip_miss;
	logic next_slip;

	always_comb begin
		slip_dup = out_word_i && !fresh && !rx_word_i;
		slip_miss = rx_word_i && fresh && !out_word_i;
		next_fresh = rx_word_i ? 1'b1 : (out_word_i ? 1'b0 : fresh);
		next_slip = slip_o;
		if (!slave_mode_i) begin
			next_slip = 1'b0;
		end else if (slip_dup || slip_miss) begin
			next_slip = 1'b1;
		end else if (out_word_i) begin
			next_slip = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt output: OR of enabled sources.
	ris_enables_t sources;
	logic next_int;

	always_comb begin
		sources = 8'h00;
		sources[`RIS_BIT_ERROR] = receive_error_pin_i;
		sources[`RIS_BIT_DETECT] = input_detect_change_i;
		sources[`RIS_BIT_LOCK] = lock_freq_update_i;
		sources[`RIS_BIT_CS] = cs_update_o;
		sources[`RIS_BIT_NONPCM] = non_pcm_detect_i;
		sources[`RIS_BIT_PC] = pc_update_o;
		sources[`RIS_BIT_SLIP] = slip_o;
		sources[`RIS_BIT_EMPH] = emphasis_detect_i;
		next_int = |(enables & sources);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State registers.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			enables <= `RIS_ENABLES_RESET;
			cs_cnt <= `RIS_CS_BITS;
			cs_cur <= 48'h000000000000;
			cs_prev <= 48'h000000000000;
			cs_prev_valid <= 1'b0;
			cs_update_o <= 1'b0;
			pc_prev <= 16'h0000;
			pc_have <= 1'b0;
			pc_update_o <= 1'b0;
			fresh <= 1'b0;
			slip_o <= 1'b0;
			int_o <= 1'b0;
		end else begin
			enables <= next_enables;
			cs_cnt <= next_cs_cnt;
			cs_cur <= next_cs_cur;
			cs_prev <= next_cs_prev;
			cs_prev_valid <= next_cs_prev_valid;
			cs_update_o <= next_cs_update;
			pc_prev <= next_pc_prev;
			pc_have <= next_pc_have;
			pc_update_o <= next_pc_update;
			fresh <= next_fresh;
			slip_o <= next_slip;
			int_o <= next_int;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions and covers.
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	chk_lock_gate: assert property (
		enables[`RIS_BIT_LOCK] && lock_freq_update_i |=> int_o)
		else $error("Enabled lock frequency update did not raise the interrupt.");

	chk_slip_gate: assert property (
		!slave_mode_i |=> !slip_o)
		else $error("Slip flag set outside slave mode.");

	chk_slip_dup: assert property (
		slave_mode_i && out_word_i && !fresh && !rx_word_i |=> slip_o ##1 (int_o
		|| !enables[`RIS_BIT_SLIP] || !$past(enables[`RIS_BIT_SLIP])))
		else $error("Duplicated read did not raise the slip flag and interrupt.");

	chk_cs_capture: assert property (
		cs_bit_valid_i && cs_block_start_i |=> cs_cnt == 6'h01 && cs_cur[0] == $past(cs_bit_i))
		else $error("First channel status bit of a block was not captured.");

	chk_cs_flag: assert property (
		$rose(cs_update_o) |-> $past(cs_cmp_now) && $past(cs_prev_valid))
		else $error("Channel status flag rose without a matching compare.");

	chk_pc_hold: assert property (
		pc_valid_i |=> pc_prev == $past(pc_value_i) && pc_have)
		else $error("Pc value of the burst was not held.");

	chk_pc_match: assert property (
		pc_valid_i && pc_have && pc_value_i != pc_prev |=> !pc_update_o)
		else $error("Pc flag raised for differing values.");

	chk_int_mask: assert property (
		enables == 8'h00 && !wr_valid |=> !int_o ##1 (!int_o || $past(enables) != 8'h00))
		else $error("Interrupt raised with every source masked.");

	cov_cs_update: cover property ($rose(cs_update_o));
	cov_pc_update: cover property ($rose(pc_update_o));
	cov_slip: cover property ($rose(slip_o));
	cov_int: cover property ($rose(int_o));

endmodule

// ---- sim/ris_host.sv ----
// Host model that writes commands over the serial control bus pins.
`timescale 1ns/1ns

module ris_host (
	input wire logic clk_sys_i, // System clock, paces the pin changes.
	output logic ctl_clk_o, // Shift clock pin.
	output logic ctl_ce_o, // Enable pin.
	output logic ctl_di_o // Data pin.
);
	initial begin
		ctl_clk_o = 1'b0;
		ctl_ce_o = 1'b0;
		ctl_di_o = 1'b0;
	end

	// Each pin level stands four system cycles, above the three needed.
	task automatic hold;
		repeat (4) @(negedge clk_sys_i);
	endtask

	task automatic bit_out(input logic b);
		ctl_di_o = b;
		hold();
		ctl_clk_o = 1'b1;
		hold();
		ctl_clk_o = 1'b0;
		hold();
	endtask

	// Address byte with enable low, then 16 data bits, both LSB first.
	task automatic send(input logic [7:0] addr, input logic [15:0] data);
		for (int i = 0; i < 8; i++) bit_out(addr[i]);
		ctl_ce_o = 1'b1;
		hold();
		for (int i = 0; i < 16; i++) bit_out(data[i]);
		ctl_ce_o = 1'b0;
		ctl_di_o = ~ctl_di_o;
		hold();
	endtask
endmodule

// ---- sim/ris_top_tb.sv ----
// Testbench for the receiver interrupt source select.
`timescale 1ns/1ns
`include "ris_map.svh"

module ris_top_tb;
	logic clk_sys, reset_n, ctl_clk, ctl_ce, ctl_di, slave, rx_w, out_w;
	logic cs_v, cs_b, cs_s, pc_v, int_s, cs_up, pc_up, slip;
	logic [7:0] src;
	logic [15:0] pc_val;
	int failures, tests_run;

	ris_host ris_host_i (.clk_sys_i(clk_sys), .ctl_clk_o(ctl_clk), .ctl_ce_o(ctl_ce),
		.ctl_di_o(ctl_di));
	ris_top ris_top_i (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .ctl_clk_i(ctl_clk),
		.ctl_ce_i(ctl_ce), .ctl_di_i(ctl_di), .chip_address_upper_i(1'b1),
		.chip_address_lower_i(1'b0), .receive_error_pin_i(src[0]),
		.input_detect_change_i(src[1]), .lock_freq_update_i(src[2]),
		.non_pcm_detect_i(src[4]), .emphasis_detect_i(src[7]), .slave_mode_i(slave),
		.rx_word_i(rx_w), .out_word_i(out_w), .cs_bit_valid_i(cs_v), .cs_bit_i(cs_b),
		.cs_block_start_i(cs_s), .pc_valid_i(pc_v), .pc_value_i(pc_val), .int_o(int_s),
		.cs_update_o(cs_up), .pc_update_o(pc_up), .slip_o(slip));

	////////////////////////////////////////////////////////////
	task summarize;
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic got, input logic exp, input string m);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task en_set(input logic [7:0] e);
		ris_host_i.send(`RIS_CHIP_ADDR, {e, `RIS_CMD_CODE, 2'b10});
		cyc(8);
	endtask

	task cs_blk(input logic [63:0] v, input logic e, input string m);
		for (int i = 0; i < 64; i++) begin
			cs_v = 1'b1;
			cs_b = v[i];
			cs_s = (i == 0);
			cyc(1);
		end
		cs_v = 1'b0;
		cs_s = 1'b0;
		cyc(2);
		chk(cs_up, e, m);
	endtask

	task pc(input logic [15:0] v, input logic e, input string m);
		pc_v = 1'b1;
		pc_val = v;
		cyc(1);
		pc_v = 1'b0;
		pc_val = ~v;
		cyc(2);
		chk(pc_up, e, m);
	endtask

	task wd(input logic r, input logic o, input logic e, input string m);
		rx_w = r;
		out_w = o;
		cyc(1);
		rx_w = 1'b0;
		out_w = 1'b0;
		cyc(2);
		chk(slip, e, m);
	endtask

	////////////////////////////////////////////////////////////
	task t_mask;
		logic [7:0] m;
		chk(int_s, 1'b0, "sources masked after reset");
		for (int k = 0; k < 8; k++) begin
			if (k == 3 || k == 5 || k == 6)
				continue;
			m = 8'h01 << k;
			en_set(m);
			src = ~m;
			cyc(3);
			chk(int_s, 1'b0, "disabled source seen");
			src = m;
			cyc(3);
			chk(int_s, 1'b1, "enabled source lost");
		end
		ris_host_i.send(8'hE9, 16'hFF82);
		ris_host_i.send(`RIS_CHIP_ADDR, 16'hFF02);
		ris_host_i.send(`RIS_CHIP_ADDR, 16'hFF81);
		cyc(8);
		src = 8'h7F;
		cyc(3);
		chk(int_s, 1'b0, "bad frame accepted");
		src = 8'h00;
	endtask

	task t_cs;
		en_set(8'h08);
		cs_blk(64'h0000_A5A5_1234_5678, 1'b0, "first block flagged");
		cs_blk(64'hFFFF_A5A5_1234_5678, 1'b1, "equal block missed");
		chk(int_s, 1'b1, "status int missing");
		cs_blk(64'hFFFF_25A5_1234_5678, 1'b0, "bit 47 ignored");
		cs_blk(64'h0000_25A5_1234_5679, 1'b0, "bit 0 ignored");
		cs_blk(64'h0000_25A5_1234_5679, 1'b1, "repeat block missed");
	endtask

	task t_pc;
		en_set(8'h20);
		pc(16'h1234, 1'b0, "first pc flagged");
		pc(16'h1234, 1'b1, "equal pc missed");
		chk(int_s, 1'b1, "pc int missing");
		pc(16'h9234, 1'b0, "differing pc flagged");
		chk(int_s, 1'b0, "masked status seen");
		pc(16'h9234, 1'b1, "repeat pc missed");
	endtask

	task t_slip;
		en_set(8'h40);
		chk(int_s, 1'b0, "masked pc seen");
		slave = 1'b1;
		wd(1'b1, 1'b0, 1'b0, "slip on write");
		wd(1'b0, 1'b1, 1'b0, "slip on clean read");
		wd(1'b0, 1'b1, 1'b1, "duplicate missed");
		chk(int_s, 1'b1, "slip int missing");
		wd(1'b1, 1'b0, 1'b1, "slip dropped early");
		wd(1'b0, 1'b1, 1'b0, "clean read kept slip");
		wd(1'b1, 1'b0, 1'b0, "slip on write");
		wd(1'b1, 1'b0, 1'b1, "missing word missed");
		slave = 1'b0;
		cyc(2);
		chk(slip, 1'b0, "slip kept as master");
		wd(1'b0, 1'b1, 1'b0, "read as master");
		wd(1'b0, 1'b1, 1'b0, "slip raised as master");
		en_set(8'h00);
		slave = 1'b1;
		wd(1'b0, 1'b1, 1'b1, "duplicate missed");
		chk(int_s, 1'b0, "masked slip seen");
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#400000;
		failures++;
		summarize();
	end

	initial begin
		reset_n = 1'b0;
		src = 8'hFF;
		{slave, rx_w, out_w, cs_v, cs_b, cs_s, pc_v} = 7'h00;
		pc_val = 16'h0000;
		failures = 0;
		tests_run = 0;
		cyc(16);
		reset_n = 1'b1;
		cyc(3);
		t_mask();
		t_cs();
		t_pc();
		t_slip();
		summarize();
	end
endmodule
